// ---- logic/twslv_top.sv ----
// Two-wire hardware slave with clock stretching and a two-entry event buffer.
// Assumes bus pins reach it unsynchronised and CPU strobes are on mclk.
`timescale 1ns/1ns
`include "twslv_map.svh"
module twslv_top import twslv_pkg::*; (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Configuration
    input  wire logic        serial_peripheral_enable_bit,
    input  wire logic        master_select_bit,
    input  wire logic        interface_reset_bit,
    input  wire logic        two_wire_irq_enable,
    input  wire logic        global_irq_enable,
    // Address register write
    input  wire logic        addr_wr_stb,
    input  wire logic [7:0]  addr_wr_data,
    // Data register access
    input  wire logic        dat_wr_stb,
    input  wire logic [7:0]  dat_wr_data,
    input  wire logic        dat_rd_stb,
    // Register views
    output logic      [7:0]  slave_address_reg,
    output logic      [7:0]  two_wire_data_reg,
    output logic      [7:0]  two_wire_control_reg,
    output logic             byte_complete_flag,
    output logic             transfer_direction_bit,
    output logic             halted,
    // Interrupt
    output logic             irq_req,
    output logic      [15:0] irq_vector,
    // Bus pins
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe_n,
    input  wire logic        serial_data_pin_in,
    output logic             serial_data_pin_out,
    output logic             serial_data_pin_oe_n
);
    twslv_state_t state_ff;
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] prev_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic       drv_ff;
    logic       hold_ff;
    logic       ack_ff;
    logic       push_ff;
    logic [7:0] push_data_ff;
    logic [7:0] addr_ff;
    logic [7:0] dat_ff;
    logic       flag_ff;
    logic       dir_ff;
    logic       acc_ff;
    logic       halt_ff;
    logic       irq_ff;
    logic [15:0] vec_ff;
    logic [7:0] ctl_ff;
    logic       scl_oe_n_ff;
    logic       sda_oe_n_ff;
    logic       scl_out_ff;
    logic       sda_out_ff;
    logic [7:0] mem_ff [0:1];
    logic       wr_ptr_ff;
    logic       rd_ptr_ff;
    logic [1:0] fcnt_ff;

    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    logic enabled, go, access, in_ready, out_valid, pop, release_ok;

    function automatic logic addr_match(input logic [7:0] b, input logic [7:0] a);
        addr_match = (b[7:1] == a[6:0]);
    endfunction : addr_match

    // Two flops per pin before any logic looks at it
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_ff[gi] <= 1'b1;
                    sync2_ff[gi] <= 1'b1;
                    prev_ff[gi]  <= 1'b1;
                end else begin
                    sync1_ff[gi] <= gi == 0 ? serial_clock_pin_in : serial_data_pin_in;
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi]  <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    assign scl_s     = sync2_ff[0];
    assign sda_s     = sync2_ff[1];
    assign scl_rise  = scl_s & ~prev_ff[0];
    assign scl_fall  = ~scl_s & prev_ff[0];
    assign start_det = scl_s & prev_ff[0] & prev_ff[1] & ~sda_s;
    assign stop_det  = scl_s & prev_ff[0] & ~prev_ff[1] & sda_s;
    // Pins are shared, so the slave only acts when the other port is off
    assign enabled   = ~serial_peripheral_enable_bit & ~master_select_bit
                       & ~interface_reset_bit & ~halt_ff;
    assign go        = enabled & ~start_det & ~stop_det;
    assign access    = dat_wr_stb | dat_rd_stb;
    assign in_ready  = (fcnt_ff != 2'h2);
    assign out_valid = (fcnt_ff != 2'h0);
    assign pop       = out_valid & ~flag_ff & ~halt_ff;
    // Stretch also waits for the buffer to drain, so bytes cannot pile up
    assign release_ok = ~flag_ff & ~out_valid & ~push_ff;

    // Bus engine
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= TW_IDLE;
            cnt_ff       <= 4'h0;
            shift_ff     <= 8'h00;
            drv_ff       <= 1'b0;
            hold_ff      <= 1'b0;
            ack_ff       <= 1'b1;
            push_ff      <= 1'b0;
            push_data_ff <= 8'h00;
            dir_ff       <= 1'b0;
        end else if (!enabled) begin
            state_ff <= TW_IDLE;
            drv_ff   <= 1'b0;
            hold_ff  <= 1'b0;
            push_ff  <= 1'b0;
        end else begin
            push_ff <= push_ff & ~in_ready;
            if (start_det) begin
                state_ff <= TW_ADDR;
                cnt_ff   <= 4'h0;
                drv_ff   <= 1'b0;
                hold_ff  <= 1'b0;
            end else if (stop_det) begin
                state_ff <= TW_IDLE;
                drv_ff   <= 1'b0;
                hold_ff  <= 1'b0;
            end else begin
                case (state_ff)
                    TW_ADDR, TW_RX: begin
                        if (hold_ff) begin
                            if (release_ok) begin
                                hold_ff <= 1'b0;
                            end
                        end else if (scl_rise && cnt_ff != `TW_BITS) begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                            cnt_ff   <= cnt_ff + 4'h1;
                        end else if (scl_fall && cnt_ff == `TW_BITS) begin
                            if (state_ff == TW_RX) begin
                                drv_ff   <= 1'b1;
                                state_ff <= TW_RACK;
                            end else if (addr_match(shift_ff, addr_ff)) begin
                                drv_ff   <= 1'b1;
                                state_ff <= TW_AACK;
                            end else begin
                                state_ff <= TW_IDLE;
                            end
                        end
                    end
                    TW_AACK, TW_RACK: begin
                        if (scl_fall) begin
                            drv_ff       <= 1'b0;
                            push_ff      <= 1'b1;
                            push_data_ff <= shift_ff;
                            hold_ff      <= 1'b1;
                            cnt_ff       <= 4'h0;
                            if (state_ff == TW_AACK) begin
                                dir_ff   <= shift_ff[0];
                                state_ff <= shift_ff[0] ? TW_TX : TW_RX;
                            end else begin
                                state_ff <= TW_RX;
                            end
                        end
                    end
                    TW_TX: begin
                        if (hold_ff) begin
                            if (release_ok) begin
                                hold_ff  <= 1'b0;
                                drv_ff   <= ~dat_ff[7];
                                shift_ff <= {dat_ff[6:0], 1'b0};
                                cnt_ff   <= 4'h1;
                            end
                        end else if (scl_fall) begin
                            if (cnt_ff == `TW_BITS) begin
                                drv_ff   <= 1'b0;
                                state_ff <= TW_TACK;
                            end else begin
                                drv_ff   <= ~shift_ff[7];
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                cnt_ff   <= cnt_ff + 4'h1;
                            end
                        end
                    end
                    TW_TACK: begin
                        if (scl_rise) begin
                            ack_ff <= sda_s;
                        end else if (scl_fall) begin
                            if (!ack_ff) begin
                                push_ff      <= 1'b1;
                                push_data_ff <= dat_ff;
                                hold_ff      <= 1'b1;
                                state_ff     <= TW_TX;
                            end else begin
                                state_ff <= TW_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_ff <= TW_IDLE;
                    end
                endcase
            end
        end
    end

    // Two-entry event buffer between the engine and the data register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ff[0] <= 8'h00;
            mem_ff[1] <= 8'h00;
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            fcnt_ff   <= 2'h0;
        end else if (interface_reset_bit) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            fcnt_ff   <= 2'h0;
        end else begin
            if (push_ff && in_ready) begin
                mem_ff[wr_ptr_ff] <= push_data_ff;
                wr_ptr_ff         <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            fcnt_ff <= fcnt_ff + {1'b0, push_ff & in_ready} - {1'b0, pop};
        end
    end

    // Flag and data register; a new event wins over a clearing access.
    // One flag serves address and data bytes alike.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flag_ff <= 1'b0;
            dat_ff  <= `TW_DAT_RST;
        end else begin
            if (pop) begin
                flag_ff <= 1'b1;
                dat_ff  <= mem_ff[rd_ptr_ff];
            end else begin
                if (access || interface_reset_bit) begin
                    flag_ff <= 1'b0;
                end
                if (dat_wr_stb) begin
                    dat_ff <= dat_wr_data;
                end
            end
        end
    end

    // Double access detection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc_ff  <= 1'b0;
            halt_ff <= 1'b0;
        end else if (interface_reset_bit) begin
            acc_ff  <= 1'b0;
            halt_ff <= 1'b0;
        end else if (pop) begin
            acc_ff <= 1'b0;
        end else if (access) begin
            acc_ff <= 1'b1;
            if (acc_ff) begin
                halt_ff <= 1'b1;
            end
        end
    end

    // Address register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            addr_ff <= `TW_ADDR_RST;
        end else if (addr_wr_stb) begin
            addr_ff <= addr_wr_data;
        end
    end

    // Interrupt, control view and pin drivers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff      <= 1'b0;
            vec_ff      <= 16'h0000;
            ctl_ff      <= 8'h00;
            scl_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            scl_out_ff  <= 1'b0;
            sda_out_ff  <= 1'b0;
        end else begin
            irq_ff <= flag_ff & two_wire_irq_enable & global_irq_enable;
            vec_ff <= irq_ff ? `TW_VECTOR : 16'h0000;
            ctl_ff <= 8'h00;
            ctl_ff[`TW_CTL_FLAG] <= flag_ff;
            ctl_ff[`TW_CTL_DIR]  <= dir_ff;
            ctl_ff[`TW_CTL_RST]  <= interface_reset_bit;
            ctl_ff[`TW_CTL_MSEL] <= master_select_bit;
            scl_oe_n_ff <= ~hold_ff;
            sda_oe_n_ff <= ~drv_ff;
            scl_out_ff  <= 1'b0;
            sda_out_ff  <= 1'b0;
        end
    end

    assign slave_address_reg      = addr_ff;
    assign two_wire_data_reg      = dat_ff;
    assign two_wire_control_reg   = ctl_ff;
    assign byte_complete_flag     = flag_ff;
    assign transfer_direction_bit = dir_ff;
    assign halted                 = halt_ff;
    assign irq_req                = irq_ff;
    assign irq_vector             = vec_ff;
    assign serial_clock_pin_out   = scl_out_ff;
    assign serial_clock_pin_oe_n  = scl_oe_n_ff;
    assign serial_data_pin_out    = sda_out_ff;
    assign serial_data_pin_oe_n   = sda_oe_n_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    disabled_goes_idle_a: assert property (
        (serial_peripheral_enable_bit || master_select_bit) |=> state_ff == TW_IDLE ##1 scl_oe_n_ff)
        else $error("slave active while disabled");
    irq_gate_a: assert property (
        irq_ff |-> $past(flag_ff && two_wire_irq_enable && global_irq_enable))
        else $error("interrupt without both enables");
    access_clears_flag_a: assert property (
        (access && flag_ff && !pop) |=> !flag_ff ##1 !irq_ff)
        else $error("access left flag set");
    second_access_halt_a: assert property (
        (access && acc_ff && !pop && !interface_reset_bit) |=> halt_ff)
        else $error("double access did not halt");
    vector_on_irq_a: assert property (
        irq_ff |=> vec_ff == `TW_VECTOR)
        else $error("wrong vector");
    stretch_hold_a: assert property (
        (flag_ff && state_ff != TW_IDLE) |=> !scl_oe_n_ff)
        else $error("clock released while flag set");
    nack_idle_a: assert property (
        (state_ff == TW_TACK && scl_fall && ack_ff && go) |=> state_ff == TW_IDLE && !push_ff)
        else $error("nack not returning idle");
    stop_idle_a: assert property (
        (stop_det && !start_det && enabled) |=> state_ff == TW_IDLE)
        else $error("stop not returning idle");
    addr_mismatch_a: assert property (
        (state_ff == TW_ADDR && scl_fall && cnt_ff == `TW_BITS && go
         && !addr_match(shift_ff, addr_ff)) |=> state_ff == TW_IDLE && !drv_ff)
        else $error("mismatched address acknowledged");
    rx_ack_drive_a: assert property (
        (state_ff == TW_RX && !hold_ff && scl_fall && cnt_ff == `TW_BITS && go)
        |=> drv_ff ##1 !sda_oe_n_ff)
        else $error("receive ack not driven");
    ifrst_idle_a: assert property (
        interface_reset_bit |=> state_ff == TW_IDLE && !halt_ff)
        else $error("interface reset ignored");
endmodule : twslv_top

// ---- logic/twslv_map.svh ----
// Constants for the two-wire hardware slave: reset values, bit positions, vector.
// Assumes inclusion by bare name from the top module only.
// Function
// - After system reset the interface comes up as hardware slave.
// - Active only with peripheral enable clear and master select clear.
// - Own address from address register; data register for receive and transmit.
// - Wait for START; valid address and direction set byte-complete flag.
// - Interrupt request needs flag, two-wire interrupt enable and global enable.
// - Any data register read or write clears flag and pending interrupt.
// - Second data access per flag event halts until interface reset.
// - Poll flag or take interrupt vectoring to fixed address per byte.
// - First byte shows received seven-bit address plus direction bit.
// - Direction bit holds master read/write; set transmits, clear receives.
// - After valid address hold clock low until flag cleared.
// - Flag set per byte only when acknowledged; none after not-acknowledge.
// - Keep flagging acknowledged bytes until STOP or interface reset.
// - STOP returns slave to idle, waiting to be addressed.
// - Not-acknowledge ending a sequence returns slave to idle.
// - Interface reset bit forces idle and clears halt.
// - No hardware indication separates address flag from data flag.
// - Pins shared with serial peripheral interface; one active at once.
// - Address register holds power-on default until software overwrites.
// - Flag at control bit 0, direction at bit 1.
`ifndef TWSLV_MAP_SVH
`define TWSLV_MAP_SVH
`define TW_ADDR_RST  8'h55
`define TW_DAT_RST   8'h00
`define TW_CTL_FLAG  0
`define TW_CTL_DIR   1
`define TW_CTL_RST   2
`define TW_CTL_MSEL  3
`define TW_VECTOR    16'h003B
`define TW_BITS      4'h8
`endif

// ---- logic/twslv_pkg.sv ----
// Types for the two-wire hardware slave.
// Assumes nothing beyond the map header.
package twslv_pkg;
    typedef enum logic [2:0] {
        TW_IDLE = 3'b000,
        TW_ADDR = 3'b001,
        TW_AACK = 3'b010,
        TW_RX   = 3'b011,
        TW_RACK = 3'b100,
        TW_TX   = 3'b101,
        TW_TACK = 3'b110
    } twslv_state_t;
endpackage : twslv_pkg

// ---- testbench/twslv_master.sv ----
// Behavioural two-wire bus master that drives the slave's pins as the far side.
// Assumes an open-drain wire with pull-up, resolved by the bench from all pulls.
`timescale 1ns/1ns
module twslv_master (
    // Resolved bus lines
    input  wire logic scl,
    input  wire logic sda,
    // Open-drain pulls, low pulls the line low
    output logic      scl_oe_n,
    output logic      sda_oe_n
);
    localparam int HALF = 160;

    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end

    // Bounded so that a slave that never lets go cannot hang the master forever
    task automatic rel_scl();
        scl_oe_n = 1'b1;
        for (int i = 0; i < 2000 && scl !== 1'b1; i++) #40;
    endtask : rel_scl

    task automatic start_cond();
        sda_oe_n = 1'b1;
        #HALF;
        rel_scl();
        #HALF;
        sda_oe_n = 1'b0;
        #HALF;
        scl_oe_n = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        sda_oe_n = 1'b0;
        #HALF;
        rel_scl();
        #HALF;
        sda_oe_n = 1'b1;
        #HALF;
    endtask : stop_cond

    // Data changes only while the clock is low; sampled mid-way through the high phase
    task automatic bit_io(input logic b, output logic r);
        #60;
        sda_oe_n = b;
        #200;
        rel_scl();
        #80;
        r = sda;
        #80;
        scl_oe_n = 1'b0;
    endtask : bit_io

    task automatic byte_io(input logic [7:0] tx, input logic ack_out,
                           output logic [7:0] rx, output logic ack_in);
        for (int k = 7; k >= 0; k--) bit_io(tx[k], rx[k]);
        bit_io(ack_out, ack_in);
    endtask : byte_io
endmodule : twslv_master

// ---- testbench/twslv_top_test.sv ----
// Self-checking bench for the two-wire hardware slave.
// Assumes the behavioural master model drives the far side of the bus.
`timescale 1ns/1ns
module twslv_top_test;
    logic        mclk, reset_n, serial_peripheral_enable_bit, master_select_bit;
    logic        interface_reset_bit, two_wire_irq_enable, global_irq_enable;
    logic        addr_wr_stb, dat_wr_stb, dat_rd_stb;
    logic [7:0]  addr_wr_data, dat_wr_data, slave_address_reg, two_wire_data_reg;
    logic [7:0]  two_wire_control_reg;
    logic        byte_complete_flag, transfer_direction_bit, halted, irq_req;
    logic [15:0] irq_vector;
    logic        serial_clock_pin_out, serial_clock_pin_oe_n, m_scl_oe_n;
    logic        serial_data_pin_out, serial_data_pin_oe_n, m_sda_oe_n;
    wire         scl_line, sda_line;
    int          miscompares, num_checks;

    // Open drain with pull-up: low if any enabled driver pulls low
    assign scl_line = m_scl_oe_n & (serial_clock_pin_oe_n | serial_clock_pin_out);
    assign sda_line = m_sda_oe_n & (serial_data_pin_oe_n | serial_data_pin_out);

    twslv_top i_twslv_top (.mclk, .reset_n, .serial_peripheral_enable_bit, .master_select_bit,
        .interface_reset_bit, .two_wire_irq_enable, .global_irq_enable, .addr_wr_stb,
        .addr_wr_data, .dat_wr_stb, .dat_wr_data, .dat_rd_stb, .slave_address_reg,
        .two_wire_data_reg, .two_wire_control_reg, .byte_complete_flag,
        .transfer_direction_bit, .halted, .irq_req, .irq_vector,
        .serial_clock_pin_in(scl_line), .serial_clock_pin_out, .serial_clock_pin_oe_n,
        .serial_data_pin_in(sda_line), .serial_data_pin_out, .serial_data_pin_oe_n);

    twslv_master i_twslv_master (.scl(scl_line), .sda(sda_line), .scl_oe_n(m_scl_oe_n),
        .sda_oe_n(m_sda_oe_n));

    always #20 mclk = ~mclk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick();
        @(posedge mclk);
        #2;
    endtask : tick

    task automatic acc(input logic rd, input logic [7:0] d);
        tick();
        dat_rd_stb = rd;
        dat_wr_stb = ~rd;
        dat_wr_data = d;
        tick();
        dat_rd_stb = 1'b0;
        dat_wr_stb = 1'b0;
    endtask : acc

    // Waits for an event, stalls the bus a while, checks the views, then does one access
    task automatic serve(input logic [7:0] exp, input logic dir, input logic rd,
                         input logic [7:0] wd);
        logic irq_exp;
        for (int i = 0; i < 3000 && byte_complete_flag !== 1'b1; i++) tick();
        repeat (50) tick();
        irq_exp = two_wire_irq_enable & global_irq_enable;
        chk("flag", 16'h0001, 16'(byte_complete_flag));
        chk("data", 16'(exp), 16'(two_wire_data_reg));
        chk("dir", 16'(dir), 16'(transfer_direction_bit));
        chk("control", 16'({dir, 1'b1}), 16'(two_wire_control_reg));
        chk("scl_stretch", 16'h0000, 16'(serial_clock_pin_oe_n));
        chk("irq", 16'(irq_exp), 16'(irq_req));
        chk("vector", irq_exp ? 16'h003B : 16'h0000, irq_vector);
        acc(rd, wd);
        tick();
        chk("flag_clear", 16'h0000, 16'(byte_complete_flag));
        chk("irq_clear", 16'h0000, 16'(irq_req));
    endtask : serve

    task automatic xfer(input logic [7:0] tx, input logic ao, input logic [7:0] erx,
                        input logic eack);
        logic [7:0] rx;
        logic       ack;
        i_twslv_master.byte_io(tx, ao, rx, ack);
        chk("ack", 16'(eack), 16'(ack));
        if (tx == 8'hFF) chk("rx", 16'(erx), 16'(rx));
    endtask : xfer

    // One addressed write carrying only the address byte, served by a read
    task automatic addr_only(input logic [7:0] a);
        fork
            begin
                i_twslv_master.start_cond();
                xfer(a, 1'b1, 8'h00, 1'b0);
                i_twslv_master.stop_cond();
            end
            serve(a, 1'b0, 1'b1, 8'h00);
        join
    endtask : addr_only

    initial begin
        #2000000;
        miscompares++;
        close_out();
    end

    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        {serial_peripheral_enable_bit, master_select_bit, interface_reset_bit} = 3'h0;
        {two_wire_irq_enable, global_irq_enable} = 2'h2;
        {addr_wr_stb, dat_wr_stb, dat_rd_stb} = 3'h0;
        addr_wr_data = 8'h00;
        dat_wr_data = 8'h00;
        repeat (8) @(posedge mclk);
        #2;
        reset_n = 1'b1;
        repeat (3) tick();
        chk("addr_reset", 16'h0055, 16'(slave_address_reg));
        chk("data_reset", 16'h0000, 16'(two_wire_data_reg));
        chk("control_reset", 16'h0000, 16'(two_wire_control_reg));
        chk("pins_reset", 16'h0003, 16'({serial_clock_pin_oe_n, serial_data_pin_oe_n}));
        $display("test reset done");
        fork
            begin
                i_twslv_master.start_cond();
                xfer(8'hAA, 1'b1, 8'h00, 1'b0);
                xfer(8'hA5, 1'b1, 8'h00, 1'b0);
                i_twslv_master.stop_cond();
            end
            begin
                serve(8'hAA, 1'b0, 1'b1, 8'h00);
                global_irq_enable = 1'b1;
                serve(8'hA5, 1'b0, 1'b1, 8'h00);
            end
        join
        $display("test slave receive done");
        fork
            begin
                i_twslv_master.start_cond();
                xfer(8'hAB, 1'b1, 8'h00, 1'b0);
                xfer(8'hFF, 1'b0, 8'h3C, 1'b0);
                xfer(8'hFF, 1'b1, 8'hC3, 1'b1);
                i_twslv_master.stop_cond();
            end
            begin
                serve(8'hAB, 1'b1, 1'b0, 8'h3C);
                serve(8'h3C, 1'b1, 1'b0, 8'hC3);
            end
        join
        repeat (20) tick();
        chk("flag_after_nack", 16'h0000, 16'(byte_complete_flag));
        $display("test slave transmit done");
        addr_wr_data = 8'h21;
        addr_wr_stb = 1'b1;
        tick();
        addr_wr_stb = 1'b0;
        tick();
        chk("addr_write", 16'h0021, 16'(slave_address_reg));
        i_twslv_master.start_cond();
        xfer(8'hAA, 1'b1, 8'h00, 1'b1);
        i_twslv_master.stop_cond();
        chk("flag_mismatch", 16'h0000, 16'(byte_complete_flag));
        addr_only(8'h42);
        $display("test address match done");
        acc(1'b1, 8'h00);
        tick();
        chk("halted", 16'h0001, 16'(halted));
        i_twslv_master.start_cond();
        xfer(8'h42, 1'b1, 8'h00, 1'b1);
        i_twslv_master.stop_cond();
        tick();
        interface_reset_bit = 1'b1;
        repeat (2) tick();
        chk("halt_cleared", 16'h0000, 16'(halted));
        chk("control_reset_bit", 16'h0004, 16'(two_wire_control_reg));
        interface_reset_bit = 1'b0;
        addr_only(8'h42);
        $display("test halt and interface reset done");
        for (int m = 0; m < 2; m++) begin
            tick();
            serial_peripheral_enable_bit = (m == 0);
            master_select_bit = (m == 1);
            tick();
            i_twslv_master.start_cond();
            xfer(8'h42, 1'b1, 8'h00, 1'b1);
            i_twslv_master.stop_cond();
            chk("pins_released", 16'h0003,
                16'({serial_clock_pin_oe_n, serial_data_pin_oe_n}));
        end
        serial_peripheral_enable_bit = 1'b0;
        master_select_bit = 1'b0;
        $display("test enables done");
        close_out();
    end
endmodule : twslv_top_test
